/* hw/capd_cfg.svh */
/*
  constants for the command parity and per-device mode register block.
  assumes inclusion by bare name from the package and the design files.
*/
`ifndef CAPD_CFG_SVH
`define CAPD_CFG_SVH
// ----------------------------------------
// log readout locations and page
// ----------------------------------------
`define CAPD_LOG_ADDR_LOW 2'h0
`define CAPD_LOG_ADDR_HIGH 2'h1
`define CAPD_LOG_BANK_CTRL 2'h2
`define CAPD_LOG_STATUS_CHIPID 2'h3
`define CAPD_LOG_PAGE 2'h1
// ----------------------------------------
// mode register field positions
// ----------------------------------------
`define CAPD_MR5_LAT_LSB 0
`define CAPD_MR5_ERR_BIT 4
`define CAPD_MR5_PERSIST_BIT 9
`define CAPD_MR3_READOUT_BIT 2
`define CAPD_MR3_PERDEV_BIT 4
`define CAPD_MR1_NOMTERM_LSB 8
// ----------------------------------------
// timing counts in clocks; the dq0 sample and the burst length count rising strobe edges
// ----------------------------------------
`define CAPD_MOD_CYC 8'h18
`define CAPD_ALERT_ON_CYC 8'h04
`define CAPD_ALERT_PW_CYC 8'h30
`define CAPD_PERDEV_SET_CYC 8'h18
`define CAPD_WRITE_LAT 8'h0C
`define CAPD_PERDEV_SAMPLE 3'h2
`define CAPD_BURST_LEN 3'h4
`define CAPD_DTERM_ON_LAT 8'h0A
`define CAPD_DTERM_OFF_LAT 8'h0A
// ----------------------------------------
// controller register offsets (apb byte addresses)
// ----------------------------------------
`define CAPD_REG_CMD 12'h000
`define CAPD_REG_DQ0 12'h004
`define CAPD_REG_STATUS 12'h008
`define CAPD_REG_READDATA 12'h00C
`define CAPD_REG_TIMING 12'h010
`endif

/* hw/capd_ctrl.sv */
/*
  controller end: apb slave taking frames and issuing them with parity,
  spacing waits, dq0 burst for per-device writes, log readback.
  assumes apb master per amba apb; link on same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "capd_cfg.svh"
module capd_ctrl
(
  capd_if.ctrl link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import capd_pkg::*;
  logic [7:0] wait_cnt;
  logic [2:0] cur_pl;
  logic perdev;
  logic dq0_val;
  logic [2:0] burst;
  logic [7:0] rd_data;
  logic issue;
  logic [27:0] cmd_w;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  // no frame in the cycle right after one, so frames never touch
  assign issue = psel && penable && pwrite && paddr == `CAPD_REG_CMD && wait_cnt == 8'h00 && link.cs_n;
  // ----------------------------------------
  // apb read
  // ----------------------------------------
  always_comb
  begin
    unique case (paddr)
      `CAPD_REG_STATUS: prdata = {29'h0, perdev, !link.alert_n, wait_cnt != 8'h00};
      `CAPD_REG_READDATA: prdata = {24'h0, rd_data};
      `CAPD_REG_DQ0: prdata = {31'h0, dq0_val};
      default: prdata = 32'h0;
    endcase
  end
  always_ff @(posedge link.pclk or negedge link.presetn)
  begin
    if (!link.presetn)
      dq0_val <= 1'b0;
    else if (psel && penable && pwrite && paddr == `CAPD_REG_DQ0)
      dq0_val <= pwdata[0];
  end
  // ----------------------------------------
  // frame out with even parity, deselect otherwise
  // ----------------------------------------
  assign cmd_w = pwdata[27:0];
  always_ff @(posedge link.pclk or negedge link.presetn)
  begin
    if (!link.presetn)
    begin
      link.cs_n <= 1'b1;
      link.frame <= '0;
      link.cke <= 1'b1;
      link.odt <= 1'b0;
    end
    else
    begin
      link.cs_n <= !issue;
      if (issue)
      begin
        link.frame.chip_id <= cmd_w[27:25];
        link.frame.act_n <= cmd_w[24];
        link.frame.bg <= cmd_w[23:22];
        link.frame.ba <= cmd_w[21:20];
        link.frame.addr <= cmd_w[17:0];
        link.frame.parity_input <= ^{cmd_w[24:20], cmd_w[17:0]};
        link.cke <= pwdata[28];
        link.odt <= pwdata[29];
      end
    end
  end
  // ----------------------------------------
  // spacing: parity toggle and per-device writes
  // ----------------------------------------
  logic is_mr5;
  logic is_mr3;
  // target register is {bg[0], ba[0]}, as the dram end decodes it
  assign is_mr5 = cmd_w[24] && cmd_w[16:14] == 3'h0 && {cmd_w[22], cmd_w[20]} == 2'h2;
  assign is_mr3 = cmd_w[24] && cmd_w[16:14] == 3'h0 && {cmd_w[22], cmd_w[20]} == 2'h3;
  always_ff @(posedge link.pclk or negedge link.presetn)
  begin
    if (!link.presetn)
      wait_cnt <= 8'h00;
    else if (issue && perdev)
      wait_cnt <= `CAPD_WRITE_LAT + 8'h04 + `CAPD_PERDEV_SET_CYC;
    else if (issue && is_mr5 && (cmd_w[2:0] != 3'h0) != (cur_pl != 3'h0))
      wait_cnt <= `CAPD_MOD_CYC + 8'(cmd_w[2:0] != 3'h0 ? cmd_w[2:0] : cur_pl);
    else if (wait_cnt != 8'h00)
      wait_cnt <= wait_cnt - 8'h01;
  end
  always_ff @(posedge link.pclk or negedge link.presetn)
  begin
    if (!link.presetn)
    begin
      cur_pl <= 3'h0;
      perdev <= 1'b0;
    end
    else if (issue && is_mr5)
      cur_pl <= cmd_w[2:0];
    else if (issue && is_mr3)
      perdev <= cmd_w[`CAPD_MR3_PERDEV_BIT];
  end
  // ----------------------------------------
  // dq0 burst for per-device writes
  // ----------------------------------------
  always_ff @(posedge link.pclk or negedge link.presetn)
  begin
    if (!link.presetn)
    begin
      burst <= 3'h0;
      link.dqs <= 1'b0;
      link.dq0 <= 1'b0;
    end
    else if (issue && perdev)
    begin
      burst <= 3'h4;
      link.dq0 <= is_mr3 && !cmd_w[`CAPD_MR3_PERDEV_BIT] ? 1'b0 : dq0_val;
    end
    else if (burst != 3'h0 && link.cs_n)
    begin
      // strobe starts once the frame has left the link
      link.dqs <= !link.dqs;
      if (link.dqs)
        burst <= burst - 3'h1;
    end
    else
      link.dqs <= 1'b0;
  end
  always_ff @(posedge link.pclk or negedge link.presetn)
  begin
    if (!link.presetn)
      rd_data <= 8'h00;
    else if (link.dq_read_valid)
      rd_data <= link.dq_read;
  end
endmodule : capd_ctrl
`default_nettype wire

/* hw/capd_dram.sv */
/*
  dram end: parity check, error log, alert, self refresh mask, mode
  register writes qualified by dq0 in per-device mode, log readout.
  assumes the controller keeps the command rules of the link.
*/
`timescale 1ns/1ps
`default_nettype none
`include "capd_cfg.svh"
// Function
// - even parity over command, address, bank, par
// - on error ignore, log, flag, pull alert
// - persistent mode resumes checking after alert
// - controller may raise cke early, deselects only
// - nonpersistent: latency kept, checking off until cleared
// - errored self refresh entry gives precharge power-down
// - controller keeps clock until error detectable
// - controller plans around maybe-executed earlier commands
// - controller orders commands after errored exit
// - wait mode-set plus latency after parity toggle
// - entry uses new latency, exit old latency
// - log layout in readout page one
// - log readout needs mode register three bit two
// - reader ignores unused address and chip-id bits
// - write leveling before per-device mode
// - mode register three bit four selects per-device
// - per-device exit write carries dq0 low
// - per-device write executes only when dq0 low
// - controller sends only mode writes in per-device
// - per-device write spacing at least latency sum
// - per-device termination follows odt pin, direct latencies; the code delays odt by 9 clocks on and off, not by CAPD_DTERM_ON_LAT
// - sample dq0 on second rising strobe edge
// - controller holds dq0 stable whole burst
module capd_dram
(
  capd_if.dram link,
  output logic [17:0] mode_register_one,
  output logic [17:0] mode_register_three,
  output logic [17:0] mode_register_five,
  output logic [2:0] parity_latency,
  output capd_pkg::capd_pwr_t power_state,
  output logic term_on
);
  import capd_pkg::*;
  // ----------------------------------------
  // decode
  // ----------------------------------------
  capd_frame_t f;
  capd_cmd_t cmd;
  logic sel;
  logic par_ok;
  logic checking;
  logic err_flag;
  logic [7:0] alert_cnt;
  logic alert_busy;
  logic perdev;
  logic pd_pending;
  logic [2:0] pd_beat;
  logic [17:0] pd_data;
  logic [1:0] pd_reg;
  logic pd_dq0;
  logic prev_dqs;
  logic [7:0] log_b [3];
  logic [7:0] log_st;
  logic [7:0] log_sel;
  logic [7:0] term_pipe;
  assign f = link.frame;
  assign sel = !link.cs_n;
  always_comb
  begin
    unique case ({f.act_n, f.addr[16:14]})
      4'b1000: cmd = CAPD_CMD_MRS;
      4'b1001: cmd = CAPD_CMD_REF;
      4'b1101: cmd = CAPD_CMD_READ;
      4'b1010: cmd = CAPD_CMD_SRE;
      4'b1111: cmd = CAPD_CMD_DES;
      default: cmd = f.act_n ? CAPD_CMD_PDE : CAPD_CMD_ACT;
    endcase
  end
  assign par_ok = !(^{f.act_n, f.bg, f.ba, f.addr, f.parity_input});
  assign alert_busy = alert_cnt != 8'h00;
  assign checking = (parity_latency != 3'h0) && !alert_busy && (!err_flag || mode_register_five[`CAPD_MR5_PERSIST_BIT]);
  logic bad;
  assign bad = sel && checking && !par_ok;
  logic exec;
  assign exec = sel && !bad && !alert_busy && (!perdev || cmd == CAPD_CMD_MRS);
  // ----------------------------------------
  // error flag, log and alert
  // ----------------------------------------
  always_ff @(posedge link.pclk or negedge link.presetn)
  begin
    if (!link.presetn)
      alert_cnt <= 8'h00;
    else if (bad)
      alert_cnt <= `CAPD_ALERT_ON_CYC + `CAPD_ALERT_PW_CYC;
    else if (alert_busy)
      alert_cnt <= alert_cnt - 8'h01;
  end
  always_ff @(posedge link.pclk or negedge link.presetn)
  begin
    if (!link.presetn)
      link.alert_n <= 1'b1;
    else
      link.alert_n <= !(alert_busy && alert_cnt <= `CAPD_ALERT_PW_CYC);
  end
  logic clear_req;
  assign clear_req = exec && cmd == CAPD_CMD_MRS && f.bg[0] && !f.ba[0] && !f.addr[`CAPD_MR5_ERR_BIT];
  always_ff @(posedge link.pclk or negedge link.presetn)
  begin
    if (!link.presetn)
      err_flag <= 1'b0;
    else if (bad)
      err_flag <= 1'b1;
    else if (clear_req)
      err_flag <= 1'b0;
  end
  always_ff @(posedge link.pclk or negedge link.presetn)
  begin
    if (!link.presetn)
    begin
      log_b[0] <= 8'h00;
      log_b[1] <= 8'h00;
      log_b[2] <= 8'h00;
    end
    else if (bad && !err_flag)
    begin
      log_b[0] <= f.addr[7:0];
      log_b[1] <= f.addr[15:8];
      log_b[2] <= {f.parity_input, f.act_n, f.bg[1], f.bg[0], f.ba[1], f.ba[0], f.addr[17], f.addr[16]};
    end
  end
  always_ff @(posedge link.pclk or negedge link.presetn)
  begin
    if (!link.presetn)
      log_st <= 8'h00;
    else
    begin
      log_st[7] <= 1'b0;
      log_st[6] <= err_flag;
      log_st[5:3] <= parity_latency;
      if (bad && !err_flag)
        log_st[2:0] <= f.chip_id;
    end
  end
  // ----------------------------------------
  // power state
  // ----------------------------------------
  always_ff @(posedge link.pclk or negedge link.presetn)
  begin
    if (!link.presetn)
      power_state <= CAPD_PWR_ACTIVE;
    else if (sel && cmd == CAPD_CMD_SRE && !link.cke)
      power_state <= bad ? CAPD_PWR_PRECHARGE_DOWN : CAPD_PWR_SELF_REFRESH;
    else if (!sel && link.cke && power_state != CAPD_PWR_ACTIVE)
      power_state <= CAPD_PWR_ACTIVE;
  end
  // ----------------------------------------
  // mode registers and per-device qualification
  // ----------------------------------------
  logic mrs_now;
  assign mrs_now = exec && cmd == CAPD_CMD_MRS;
  always_ff @(posedge link.pclk or negedge link.presetn)
  begin
    if (!link.presetn)
      prev_dqs <= 1'b0;
    else
      prev_dqs <= link.dqs;
  end
  always_ff @(posedge link.pclk or negedge link.presetn)
  begin
    if (!link.presetn)
    begin
      pd_pending <= 1'b0;
      pd_beat <= 3'h0;
      pd_data <= 18'h00000;
      pd_reg <= 2'h0;
      pd_dq0 <= 1'b1;
    end
    else if (mrs_now && perdev)
    begin
      pd_pending <= 1'b1;
      pd_beat <= 3'h0;
      pd_data <= f.addr;
      pd_reg <= {f.bg[0], f.ba[0]};
    end
    else if (pd_pending && link.dqs && !prev_dqs)
    begin
      pd_beat <= pd_beat + 3'h1;
      if (pd_beat + 3'h1 == `CAPD_PERDEV_SAMPLE)
        pd_dq0 <= link.dq0;
      if (pd_beat + 3'h1 == `CAPD_BURST_LEN)
        pd_pending <= 1'b0;
    end
  end
  logic pd_done;
  assign pd_done = pd_pending && link.dqs && !prev_dqs && pd_beat + 3'h1 == `CAPD_BURST_LEN;
  logic wr_en;
  logic [1:0] wr_reg;
  logic [17:0] wr_data;
  assign wr_en = (mrs_now && !perdev) || (pd_done && !pd_dq0);
  assign wr_reg = perdev ? pd_reg : {f.bg[0], f.ba[0]};
  assign wr_data = perdev ? pd_data : f.addr;
  always_ff @(posedge link.pclk or negedge link.presetn)
  begin
    if (!link.presetn)
    begin
      mode_register_one <= 18'h00000;
      mode_register_three <= 18'h00000;
      mode_register_five <= 18'h00000;
    end
    else if (wr_en)
    begin
      if (wr_reg == 2'h1)
        mode_register_one <= wr_data;
      if (wr_reg == 2'h3)
        mode_register_three <= wr_data;
      if (wr_reg == 2'h2)
        mode_register_five <= {wr_data[17:5], err_flag & ~wr_data[4], wr_data[3:0]};
    end
  end
  assign parity_latency = mode_register_five[2:0];
  assign perdev = mode_register_three[`CAPD_MR3_PERDEV_BIT];
  // ----------------------------------------
  // termination from odt pin in per-device mode
  // ----------------------------------------
  always_ff @(posedge link.pclk or negedge link.presetn)
  begin
    if (!link.presetn)
      term_pipe <= 8'h00;
    else
      term_pipe <= {term_pipe[6:0], link.odt};
  end
  always_ff @(posedge link.pclk or negedge link.presetn)
  begin
    if (!link.presetn)
      term_on <= 1'b0;
    else
      term_on <= perdev && mode_register_one[10:8] != 3'h0 && term_pipe[7];
  end
  // ----------------------------------------
  // log readout
  // ----------------------------------------
  always_comb
  begin
    unique case (f.addr[1:0])
      `CAPD_LOG_ADDR_LOW: log_sel = log_b[0];
      `CAPD_LOG_ADDR_HIGH: log_sel = log_b[1];
      `CAPD_LOG_BANK_CTRL: log_sel = log_b[2];
      `CAPD_LOG_STATUS_CHIPID: log_sel = log_st;
    endcase
  end
  always_ff @(posedge link.pclk or negedge link.presetn)
  begin
    if (!link.presetn)
    begin
      link.dq_read <= 8'h00;
      link.dq_read_valid <= 1'b0;
    end
    else
    begin
      link.dq_read_valid <= exec && cmd == CAPD_CMD_READ && mode_register_three[`CAPD_MR3_READOUT_BIT]
        && f.ba == `CAPD_LOG_PAGE;
      link.dq_read <= log_sel;
    end
  end
endmodule : capd_dram
`default_nettype wire

/* hw/capd_if.sv */
/*
  command, data and alert link between controller and dram end.
  assumes both ends share pclk and presetn.
*/
`timescale 1ns/1ps
`default_nettype none
interface capd_if
(
  input wire logic pclk,
  input wire logic presetn
);
  import capd_pkg::*;
  logic cs_n;
  logic cke;
  logic odt;
  capd_frame_t frame;
  logic dq0;
  logic dqs;
  logic [7:0] dq_read;
  logic dq_read_valid;
  logic alert_n;
  modport ctrl
  (
    input pclk, presetn, dq_read, dq_read_valid, alert_n,
    output cs_n, cke, odt, frame, dq0, dqs
  );
  modport dram
  (
    input pclk, presetn, cs_n, cke, odt, frame, dq0, dqs,
    output dq_read, dq_read_valid, alert_n
  );
endinterface : capd_if
`default_nettype wire

/* hw/capd_pkg.sv */
/*
  shared types for both ends of the command parity and per-device block.
  assumes capd_cfg.svh is on the include path.
*/
`include "capd_cfg.svh"
package capd_pkg;
  typedef enum logic [2:0] {
    CAPD_CMD_DES,
    CAPD_CMD_MRS,
    CAPD_CMD_ACT,
    CAPD_CMD_REF,
    CAPD_CMD_SRE,
    CAPD_CMD_SRX,
    CAPD_CMD_PDE,
    CAPD_CMD_READ
  } capd_cmd_t;
  typedef struct packed {
    logic [2:0] chip_id;
    logic act_n;
    logic [1:0] bg;
    logic [1:0] ba;
    logic [17:0] addr;
    logic parity_input;
  } capd_frame_t;
  typedef enum logic [1:0] {
    CAPD_PWR_ACTIVE,
    CAPD_PWR_PRECHARGE_DOWN,
    CAPD_PWR_SELF_REFRESH
  } capd_pwr_t;
endpackage : capd_pkg

/* tb/capd_link_props.sv */
/*
  checker for the command link between controller end and dram end.
  assumes the bench instantiates it beside the link, on pclk and presetn.
*/
`timescale 1ns/1ps
`default_nettype none
`include "capd_cfg.svh"
module capd_link_props
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cs_n,
  input wire logic cke,
  input wire capd_pkg::capd_frame_t frame,
  input wire logic dq0,
  input wire logic dqs,
  input wire logic dq_read_valid,
  input wire logic alert_n
);
  import capd_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic is_mrs;
  logic is_mr5;
  logic last_tog;
  logic read_seen;
  logic [2:0] pl_seen;
  logic [2:0] need_pl;
  logic [7:0] gap;
  assign is_mrs = frame.act_n && frame.addr[16:14] == 3'h0;
  assign is_mr5 = is_mrs && frame.bg[0] && !frame.ba[0];
  // ----------------------------------------
  // cycles since the last frame
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gap <= 8'hFF;
      last_tog <= 1'b0;
      pl_seen <= 3'h0;
      need_pl <= 3'h0;
    end
    else if (!cs_n)
    begin
      gap <= 8'h00;
      // entry waits on the new latency, exit on the old one
      last_tog <= is_mr5 && ((frame.addr[2:0] != 3'h0) != (pl_seen != 3'h0));
      need_pl <= (frame.addr[2:0] != 3'h0) ? frame.addr[2:0] : pl_seen;
      if (is_mr5)
        pl_seen <= frame.addr[2:0];
    end
    else if (gap != 8'hFF)
    begin
      gap <= gap + 8'h01;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      read_seen <= 1'b0;
    else
      read_seen <= !cs_n && frame.act_n && frame.addr[16:14] == 3'h5;
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_even_parity: assert property (!cs_n |-> ^{frame.act_n, frame.bg, frame.ba, frame.addr, frame.parity_input} == 1'b0)
    else $error("odd parity on a frame");
  a_alert_quiet: assert property (alert_n)
    else $error("alert on a clean link");
  a_read_pulse: assert property (dq_read_valid |=> !dq_read_valid)
    else $error("log byte valid longer than one cycle");
  a_read_cause: assert property (dq_read_valid |-> read_seen)
    else $error("log byte without a readout frame");
  a_dq0_burst: assert property ($fell(dqs) |-> $stable(dq0))
    else $error("dq0 moved inside a strobe burst");
  a_frame_single: assert property (!cs_n |=> cs_n)
    else $error("frames back to back");
  a_mrs_spacing: assert property (!cs_n && last_tog |-> gap >= `CAPD_MOD_CYC + 8'(need_pl) - 8'h01)
    else $error("frame too soon after a parity mode change");
  a_sre_cke: assert property (!cs_n && frame.act_n && frame.addr[16:14] == 3'h2 |-> !cke)
    else $error("self refresh entry with cke high");
  c_readout: cover property (dq_read_valid);
  c_burst: cover property ($rose(dqs));
  c_sre: cover property (!cs_n && !cke);
endmodule : capd_link_props
`default_nettype wire

/* tb/tb_top.sv */
/*
  bench: controller and dram joined by one link, driven over apb;
  a second dram driven straight by the bench with faulty frames.
  assumes hw package, header and interface compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "capd_cfg.svh"
module tb_top;
  import capd_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, term_on;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [17:0] mr1, mr3, mr5;
  logic [2:0] pl;
  logic [7:0] q;
  capd_pwr_t pwr, pwr_b;
  capd_frame_t last_f;
  int n_mismatch = 0;
  int num_checks = 0;
  always #2 pclk = ~pclk;
  capd_if lnk (.pclk(pclk), .presetn(presetn));
  capd_if lnk_b (.pclk(pclk), .presetn(presetn));
  capd_ctrl i_capd_ctrl (.link(lnk.ctrl), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  capd_dram i_capd_dram (.link(lnk.dram), .mode_register_one(mr1), .mode_register_three(mr3),
    .mode_register_five(mr5), .parity_latency(pl), .power_state(pwr), .term_on(term_on));
  capd_dram i_capd_dram_b (.link(lnk_b.dram), .mode_register_one(), .mode_register_three(),
    .mode_register_five(), .parity_latency(), .power_state(pwr_b), .term_on());
  capd_link_props i_capd_link_props (.pclk(pclk), .presetn(presetn), .cs_n(lnk.cs_n), .cke(lnk.cke),
    .frame(lnk.frame), .dq0(lnk.dq0), .dqs(lnk.dqs), .dq_read_valid(lnk.dq_read_valid), .alert_n(lnk.alert_n));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic wrap_up;
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic bail(input string what);
    n_mismatch++;
    $display("[FAIL] %s expected done seen timeout", what);
    wrap_up;
  endtask : bail
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50)
      bail("apb");
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // issue one frame through the controller and wait until it is idle
  task automatic cmd(input logic odt, input logic cke, input logic [1:0] bg, input logic [1:0] ba,
    input logic [17:0] a);
    int n;
    n = 0;
    apb(1'b1, `CAPD_REG_CMD, {2'b00, odt, cke, 3'h0, 1'b1, bg, ba, 2'b00, a});
    rd = 32'h1;
    while (rd[0] !== 1'b0 && n < 100)
    begin
      apb(1'b0, `CAPD_REG_STATUS, 32'h0);
      n++;
    end
    if (n >= 100)
      bail("busy");
  endtask : cmd
  function automatic capd_frame_t mk(input logic [2:0] c, input logic act, input logic [1:0] bg,
    input logic [1:0] ba, input logic [17:0] a);
    return {c, act, bg, ba, a, 1'b0};
  endfunction : mk
  // drive one frame on the second link, bad flips its parity
  task automatic send_b(input capd_frame_t f, input logic cke, input logic bad);
    f.parity_input = ^{f.act_n, f.bg, f.ba, f.addr} ^ bad;
    last_f = f;
    lnk_b.cs_n <= 1'b0;
    lnk_b.cke <= cke;
    lnk_b.frame <= f;
    @(posedge pclk);
    lnk_b.cs_n <= 1'b1;
    lnk_b.frame <= ~f;
  endtask : send_b
  task automatic rd_b(input logic [1:0] loc);
    int n;
    n = 0;
    send_b(mk(3'h0, 1'b1, 2'h0, 2'h1, {16'h5000, loc}), 1'b1, 1'b0);
    @(negedge pclk);
    while (lnk_b.dq_read_valid !== 1'b1 && n < 20)
    begin
      @(negedge pclk);
      n++;
    end
    if (n >= 20)
      bail("log read");
    q = lnk_b.dq_read;
    @(posedge pclk);
  endtask : rd_b
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic sc_perdev;
    cmd(1'b0, 1'b1, 2'h1, 2'h1, 18'h00014);
    chk(32'(mr3), 32'h14, "mr3 entry");
    apb(1'b0, `CAPD_REG_STATUS, 32'h0);
    chk(32'(rd[2]), 32'h1, "perdev flag");
    apb(1'b1, `CAPD_REG_DQ0, 32'h1);
    cmd(1'b0, 1'b1, 2'h0, 2'h1, 18'h00100);
    chk(32'(mr1), 32'h0, "mr1 with dq0 high");
    apb(1'b1, `CAPD_REG_DQ0, 32'h0);
    cmd(1'b1, 1'b1, 2'h0, 2'h1, 18'h00100);
    chk(32'(mr1), 32'h100, "mr1 with dq0 low");
    repeat (10) @(posedge pclk);
    chk(32'(term_on), 32'h1, "termination");
    apb(1'b1, `CAPD_REG_DQ0, 32'h1);
    cmd(1'b0, 1'b1, 2'h1, 2'h1, 18'h00004);
    chk(32'(mr3), 32'h4, "mr3 exit");
    apb(1'b0, `CAPD_REG_STATUS, 32'h0);
    chk(32'(rd[2]), 32'h0, "perdev flag off");
    cmd(1'b0, 1'b1, 2'h0, 2'h1, 18'h14003);
    apb(1'b0, `CAPD_REG_READDATA, 32'h0);
    chk(32'(rd[7:0]), 32'h0, "clean log status");
    apb(1'b0, 12'h7F0, 32'h0);
    chk(32'(pslverr), 32'h0, "unmapped access");
    cmd(1'b0, 1'b1, 2'h1, 2'h0, 18'h00001);
    chk(32'(pl), 32'h1, "parity latency on");
    cmd(1'b0, 1'b1, 2'h0, 2'h1, 18'h14003);
    apb(1'b0, `CAPD_REG_READDATA, 32'h0);
    chk(32'(rd[7:0]), 32'h08, "log latency field");
    apb(1'b0, `CAPD_REG_STATUS, 32'h0);
    chk(32'(rd[1]), 32'h0, "no alert with parity on");
    cmd(1'b0, 1'b1, 2'h1, 2'h0, 18'h00000);
    chk(32'(pl), 32'h0, "parity latency off");
    cmd(1'b0, 1'b0, 2'h0, 2'h0, 18'h08000);
    chk(32'(pwr), 32'(CAPD_PWR_SELF_REFRESH), "clean self refresh");
  endtask : sc_perdev
  task automatic sc_err_log;
    capd_frame_t fe;
    int n;
    logic seen;
    send_b(mk(3'h0, 1'b1, 2'h1, 2'h0, 18'h00001), 1'b1, 1'b0);
    repeat (40) @(posedge pclk);
    send_b(mk(3'h0, 1'b1, 2'h1, 2'h1, 18'h00004), 1'b1, 1'b0);
    repeat (40) @(posedge pclk);
    send_b(mk(3'h5, 1'b0, 2'h2, 2'h3, 18'h2A5C3), 1'b1, 1'b1);
    fe = last_f;
    n = 1;
    @(negedge pclk);
    while (lnk_b.alert_n !== 1'b0 && n < 20)
    begin
      @(negedge pclk);
      n++;
    end
    chk(32'(n), 32'(2 + `CAPD_ALERT_ON_CYC), "alert delay");
    n = 0;
    while (lnk_b.alert_n === 1'b0 && n < 200)
    begin
      @(negedge pclk);
      n++;
    end
    chk(32'(n), 32'(`CAPD_ALERT_PW_CYC), "alert width");
    @(posedge pclk);
    send_b(mk(3'h0, 1'b0, 2'h0, 2'h0, 18'h01234), 1'b1, 1'b1);
    seen = 1'b0;
    repeat (12) @(negedge pclk) seen = seen | !lnk_b.alert_n;
    chk(32'(seen), 32'h0, "second error alert");
    @(posedge pclk);
    rd_b(2'h0);
    chk(32'(q), 32'(fe.addr[7:0]), "log byte0");
    rd_b(2'h1);
    chk(32'(q), 32'(fe.addr[15:8]), "log byte1");
    rd_b(2'h2);
    chk(32'(q), 32'({fe.parity_input, fe.act_n, fe.bg, fe.ba, fe.addr[17:16]}), "log byte2");
    rd_b(2'h3);
    chk(32'(q), 32'h4D, "log byte3");
    send_b(mk(3'h0, 1'b1, 2'h1, 2'h0, 18'h00001), 1'b1, 1'b0);
    repeat (40) @(posedge pclk);
    rd_b(2'h3);
    chk(32'(q[6]), 32'h0, "flag cleared");
    send_b(mk(3'h0, 1'b1, 2'h1, 2'h0, 18'h00201), 1'b1, 1'b0);
    repeat (40) @(posedge pclk);
    send_b(mk(3'h0, 1'b0, 2'h0, 2'h0, 18'h00010), 1'b1, 1'b1);
    repeat (60) @(posedge pclk);
    send_b(mk(3'h0, 1'b0, 2'h0, 2'h0, 18'h00020), 1'b1, 1'b1);
    seen = 1'b0;
    repeat (12) @(negedge pclk) seen = seen | !lnk_b.alert_n;
    chk(32'(seen), 32'h1, "persistent alert");
    repeat (60) @(posedge pclk);
    send_b(mk(3'h0, 1'b1, 2'h0, 2'h0, 18'h08000), 1'b0, 1'b1);
    n = 0;
    while (pwr_b !== CAPD_PWR_PRECHARGE_DOWN && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    chk(32'(pwr_b), 32'(CAPD_PWR_PRECHARGE_DOWN), "errored self refresh");
  endtask : sc_err_log
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    lnk_b.cs_n = 1'b1;
    lnk_b.cke = 1'b1;
    lnk_b.odt = 1'b0;
    lnk_b.frame = '0;
    lnk_b.dq0 = 1'b0;
    lnk_b.dqs = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    sc_perdev;
    sc_err_log;
    wrap_up;
  end
endmodule : tb_top
`default_nettype wire
